// ==== pkg/sirq_defines.svh ====
// Offsets, field positions, reset values and frame counts for serial irq host.
`ifndef SIRQ_DEFINES_SVH
`define SIRQ_DEFINES_SVH
`define SIRQ_CTRL_OFFSET     8'h64
`define SIRQ_CTRL_RESET      8'h00
`define SIRQ_CTRL_WMASK      8'hC3
`define SIRQ_CTRL_EN_BIT     7
`define SIRQ_CTRL_CONT_BIT   6
`define SIRQ_CTRL_WIDTH_LSB  0
`define SIRQ_START_W4        4'h4
`define SIRQ_START_W6        4'h6
`define SIRQ_START_W8        4'h8
`define SIRQ_STOP_QUIET      4'h2
`define SIRQ_STOP_CONT       4'h3
`define SIRQ_FRAMES          5'h15
`define SIRQ_FRAME_SMI       2
`define SIRQ_FRAME_CHK       16
`define SIRQ_FRAME_PCI       17
`define SIRQ_LVL_RESET       21'h1F_0004
`define SIRQ_ISA_IGNORE      16'h2105
`define SIRQ_SAMPLE_DELAY    3
`define SIRQ_WAIT_GUARD      4'h3
`endif

// ==== pkg/sirq_pkg.sv ====
// Types shared by the serial irq host.
package sirq_pkg;
  typedef enum logic [6:0] {
    SIRQ_IDLE  = 7'b000_0001,
    SIRQ_START = 7'b000_0010,
    SIRQ_DATA  = 7'b000_0100,
    SIRQ_STOP  = 7'b000_1000,
    SIRQ_RCV   = 7'b001_0000,
    SIRQ_TURN  = 7'b010_0000,
    SIRQ_WAIT  = 7'b100_0000
  } sirq_state_e;
  typedef logic [7:0] sirq_byte_t;
endpackage

// ==== rtl/sirq_host.sv ====
// Serial interrupt line host: start, data sampling and stop frames.
`timescale 1ns/10ps
`include "sirq_defines.svh"
module sirq_host
  import sirq_pkg::*;
(
  input  wire logic               sys_clk,                // 20 MHz clock
  input  wire logic               rst,                    // Sync reset
  input  wire logic [7:0]         cfg_addr,               // Config offset
  input  wire logic               cfg_wr,                 // Config write
  input  wire sirq_pkg::sirq_byte_t cfg_wdata,            // Write data
  output sirq_pkg::sirq_byte_t    cfg_rdata_q,            // Read data
  input  wire logic               serial_irq_line_in,     // Line level
  output logic                    serial_irq_line_out_q,  // Line drive
  output logic                    serial_irq_line_oe_n_q, // Drive enable
  input  wire logic [3:0]         pci_int_n,              // PCI int pins
  input  wire logic [1:0]         ide_irq_in,             // ISA 14/15 pins
  input  wire logic               smi_status_clr,         // Clear status
  output logic [15:0]             isa_irq_q,              // ISA levels
  output logic [3:0]              pci_irq_route_q,        // Routes, low
  output logic                    system_mgmt_interrupt_n_q, // SMI, low
  output logic                    serial_smi_status_q,    // Sticky status
  output logic                    io_channel_check_frame_q, // Check active
  output logic [1:0]              bmide_irq_q             // IDE interrupts
);
  import sirq_pkg::*;

  sirq_state_e st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [4:0]  fr_q, fr_d;
  logic [1:0]  ph_q, ph_d;
  logic        hs_q, hs_d;
  logic        cont_q, cont_d;
  logic [7:0]  ctrl_q;
  logic        line_s1_q, line_s2_q;
  logic [3:0]  pci_s1_q, pci_s2_q;
  logic [1:0]  ide_s1_q, ide_s2_q;
  logic [2:0]  samp_v_q;
  logic [4:0]  samp_i_q [3];
  logic [20:0] lvl_q;

  function automatic logic [3:0] start_len(input logic [1:0] sel);
    case (sel)
      2'b00:   start_len = `SIRQ_START_W4;
      2'b01:   start_len = `SIRQ_START_W6;
      default: start_len = `SIRQ_START_W8;
    endcase
  endfunction

  wire        en       = ctrl_q[`SIRQ_CTRL_EN_BIT];
  wire [3:0]  st_len   = start_len(ctrl_q[`SIRQ_CTRL_WIDTH_LSB +: 2]);
  wire [3:0]  st_need  = hs_q ? st_len : st_len - 4'h1;
  wire [3:0]  sp_need  = cont_q ? `SIRQ_STOP_CONT : `SIRQ_STOP_QUIET;
  wire        drv_low  = (st_q == SIRQ_START) || (st_q == SIRQ_STOP);
  wire        drv_high = (st_q == SIRQ_RCV) ||
                         ((st_q == SIRQ_DATA) && {fr_q, ph_q} == 7'h0);
  wire        samp_now = (st_q == SIRQ_DATA) && (ph_q == 2'd2);
  wire        cap_v    = samp_v_q[2];
  wire [4:0]  cap_i    = samp_i_q[2];
  wire        cfg_hit  = cfg_addr == `SIRQ_CTRL_OFFSET;
  wire        smi_set  = cap_v && (cap_i == 5'(`SIRQ_FRAME_SMI)) &&
                         !line_s2_q;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    fr_d   = fr_q;
    ph_d   = ph_q;
    hs_d   = hs_q;
    cont_d = cont_q;
    case (st_q)
      SIRQ_IDLE: begin
        if (en) begin
          st_d   = SIRQ_START;
          cnt_d  = 4'h0;
          hs_d   = 1'b1;
          cont_d = 1'b1;
        end
      end
      SIRQ_START: begin
        if (cnt_q == st_need - 4'h1) begin
          st_d = SIRQ_DATA;
          ph_d = 2'd0;
          fr_d = 5'h0;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      SIRQ_DATA: begin
        ph_d = (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
        if (ph_q == 2'd2) begin
          fr_d = fr_q + 5'h1;
        end
        if ((ph_q == 2'd1) && (fr_q == `SIRQ_FRAMES)) begin
          st_d   = SIRQ_STOP;
          cnt_d  = 4'h0;
          cont_d = ctrl_q[`SIRQ_CTRL_CONT_BIT];
        end
      end
      SIRQ_STOP: begin
        if (cnt_q == sp_need - 4'h1) begin
          st_d = SIRQ_RCV;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      SIRQ_RCV: begin
        st_d = SIRQ_TURN;
      end
      SIRQ_TURN: begin
        cnt_d = 4'h0;
        hs_d  = 1'b1;
        st_d  = cont_q ? SIRQ_START : SIRQ_WAIT;
      end
      SIRQ_WAIT: begin
        // The synchroniser still holds our own stop frame for a few clocks.
        if (cnt_q != `SIRQ_WAIT_GUARD) begin
          cnt_d = cnt_q + 4'h1;
        end else if (!line_s2_q) begin
          st_d  = SIRQ_START;
          cnt_d = 4'h0;
          hs_d  = 1'b0;
        end
      end
      default: begin
        st_d = SIRQ_IDLE;
      end
    endcase
    if (!en) begin
      st_d = SIRQ_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q   <= SIRQ_IDLE;
      cnt_q  <= 4'h0;
      fr_q   <= 5'h0;
      ph_q   <= 2'd0;
      hs_q   <= 1'b1;
      cont_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      fr_q   <= fr_d;
      ph_q   <= ph_d;
      hs_q   <= hs_d;
      cont_q <= cont_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      pci_s1_q  <= 4'hF;
      pci_s2_q  <= 4'hF;
      ide_s1_q  <= 2'h0;
      ide_s2_q  <= 2'h0;
    end else begin
      line_s1_q <= serial_irq_line_in;
      line_s2_q <= line_s1_q;
      pci_s1_q  <= pci_int_n;
      pci_s2_q  <= pci_s1_q;
      ide_s1_q  <= ide_irq_in;
      ide_s2_q  <= ide_s1_q;
    end
  end

  // The pin is registered and the input passes two flops, so a sample
  // phase shows at the second synchroniser stage three clocks later.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      samp_v_q    <= 3'h0;
      samp_i_q[0] <= 5'h0;
      samp_i_q[1] <= 5'h0;
      samp_i_q[2] <= 5'h0;
    end else begin
      samp_v_q    <= {samp_v_q[1:0], samp_now};
      samp_i_q[0] <= fr_q;
      samp_i_q[1] <= samp_i_q[0];
      samp_i_q[2] <= samp_i_q[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvl_q <= `SIRQ_LVL_RESET;
    end else if (cap_v && (cap_i < `SIRQ_FRAMES)) begin
      lvl_q[cap_i] <= line_s2_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_irq_line_out_q  <= 1'b1;
      serial_irq_line_oe_n_q <= 1'b1;
    end else begin
      serial_irq_line_out_q  <= !drv_low;
      serial_irq_line_oe_n_q <= !(drv_low || drv_high);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      isa_irq_q                 <= 16'h0000;
      pci_irq_route_q           <= 4'hF;
      system_mgmt_interrupt_n_q <= 1'b1;
      io_channel_check_frame_q  <= 1'b0;
      bmide_irq_q               <= 2'h0;
    end else begin
      isa_irq_q <= lvl_q[15:0] & ~`SIRQ_ISA_IGNORE;
      pci_irq_route_q <= lvl_q[`SIRQ_FRAME_PCI +: 4] & pci_s2_q;
      system_mgmt_interrupt_n_q <= lvl_q[`SIRQ_FRAME_SMI];
      io_channel_check_frame_q  <= !lvl_q[`SIRQ_FRAME_CHK];
      bmide_irq_q <= ide_s2_q;
    end
  end

  // A frame that lands in the cycle of a clear keeps the flag set.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_smi_status_q <= 1'b0;
    end else if (smi_set) begin
      serial_smi_status_q <= 1'b1;
    end else if (smi_status_clr) begin
      serial_smi_status_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q      <= `SIRQ_CTRL_RESET;
      cfg_rdata_q <= 8'h00;
    end else begin
      if (cfg_wr && cfg_hit) begin
        ctrl_q <= cfg_wdata & `SIRQ_CTRL_WMASK;
      end
      cfg_rdata_q <= cfg_hit ? ctrl_q : 8'h00;
    end
  end

  logic [3:0] lowrun_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lowrun_q <= 4'h0;
    end else if (!serial_irq_line_oe_n_q && !serial_irq_line_out_q) begin
      lowrun_q <= lowrun_q + 4'h1;
    end else begin
      lowrun_q <= 4'h0;
    end
  end

  property p_high_then_release;
    @(posedge sys_clk) disable iff (rst)
    ($rose(serial_irq_line_out_q) && !serial_irq_line_oe_n_q)
      |=> serial_irq_line_oe_n_q;
  endproperty
  a_high_then_release: assert property (p_high_then_release)
    else $error("line not released after high drive");

  property p_start_width;
    @(posedge sys_clk) disable iff (rst)
    (st_q == SIRQ_DATA && ph_q == 2'd1 && fr_q == 5'h0)
      |-> lowrun_q == (hs_q ? st_len : st_len - 4'h1);
  endproperty
  a_start_width: assert property (p_start_width)
    else $error("start frame width wrong");

  property p_stop_width;
    @(posedge sys_clk) disable iff (rst)
    (st_q == SIRQ_TURN) |-> lowrun_q == sp_need;
  endproperty
  a_stop_width: assert property (p_stop_width)
    else $error("stop frame width wrong");

  property p_cont_restart;
    @(posedge sys_clk) disable iff (rst)
    (st_q == SIRQ_TURN && cont_q && en) |=> st_q == SIRQ_START && hs_q;
  endproperty
  a_cont_restart: assert property (p_cont_restart)
    else $error("continuous mode did not restart");

  property p_enable_cont;
    @(posedge sys_clk) disable iff (rst)
    (st_q == SIRQ_IDLE && en) |=> st_q == SIRQ_START && hs_q ##1 cont_q;
  endproperty
  a_enable_cont: assert property (p_enable_cont)
    else $error("enable did not start continuous mode");

  property p_turn_released;
    @(posedge sys_clk) disable iff (rst)
    (samp_now && fr_q != 5'h0) |-> $past(ph_q, 1) == 2'd1 &&
      $past(ph_q, 2) == 2'd0 ##1 serial_irq_line_oe_n_q [*2];
  endproperty
  a_turn_released: assert property (p_turn_released)
    else $error("data frame phases broken");

  property p_ignored_isa;
    @(posedge sys_clk) disable iff (rst)
    (isa_irq_q & `SIRQ_ISA_IGNORE) == 16'h0000;
  endproperty
  a_ignored_isa: assert property (p_ignored_isa)
    else $error("ignored frame reached isa output");

  property p_pci_and;
    @(posedge sys_clk) disable iff (rst)
    (!pci_s2_q[0]) |=> !pci_irq_route_q[0];
  endproperty
  a_pci_and: assert property (p_pci_and)
    else $error("pci input not ANDed into route");

  property p_smi_frame;
    @(posedge sys_clk) disable iff (rst)
    smi_set |=> serial_smi_status_q ##1 !system_mgmt_interrupt_n_q;
  endproperty
  a_smi_frame: assert property (p_smi_frame)
    else $error("management frame not acted on");

endmodule // sirq_host

// ==== sim/sirq_periph.sv ====
// Behavioural model of the peripherals sharing the serial interrupt line.
`timescale 1ns/10ps
module sirq_periph (
  input  wire logic        sys_clk,   // Bus clock
  input  wire logic        p_rst,     // Back to idle
  input  wire logic        line,      // Resolved line level
  input  wire logic [20:0] frame_lvl, // Level per frame
  input  wire logic        kick,      // Begin a quiet start
  output logic             drv_low,   // Pulls the line low
  output logic [1:0]       phase_q,   // Idle, start, data, stop
  output logic             done_q     // Cycle finished
);
  logic [6:0] cnt_q;
  logic [2:0] kick_q;
  logic [1:0] stop_q;
  logic       quiet_q;
  wire  logic [6:0] rel_w = cnt_q - 7'd2;
  // The recovery high equals the pull-up level, so only low is modelled.
  assign drv_low = (kick_q != 3'd0) || (phase_q == 2'd2
    && cnt_q >= 7'd2 && cnt_q <= 7'd62 && rel_w % 3 == 0
    && !frame_lvl[rel_w / 3]);
  always @(posedge sys_clk) begin
    done_q <= 1'b0;
    if (kick_q != 3'd0) kick_q <= kick_q - 3'd1;
    if (p_rst) begin
      phase_q <= 2'd0;
      kick_q <= 3'd0;
      quiet_q <= 1'b0;
    end else begin
      case (phase_q)
        2'd0: if (!line) phase_q <= 2'd1;
          else if (kick && quiet_q) kick_q <= 3'd5;
        2'd1: if (line) begin
          phase_q <= 2'd2;
          cnt_q <= 7'd1;
        end
        2'd2: begin
          cnt_q <= cnt_q + 7'd1;
          if (cnt_q == 7'd64) begin
            phase_q <= 2'd3;
            stop_q <= 2'd0;
          end
        end
        default: if (!line) stop_q <= stop_q + 2'd1;
          else if (stop_q != 2'd0) begin
            phase_q <= 2'd0;
            quiet_q <= (stop_q == 2'd2);
            done_q <= 1'b1;
          end
      endcase
    end
  end
endmodule // sirq_periph

// ==== sim/tb.sv ====
// Self-checking bench for the serial interrupt line host.
`timescale 1ns/10ps
module tb;
  import sirq_pkg::*;
  typedef struct packed {
    logic [15:0] isa;
    logic [3:0]  pci;
    logic        smi_n;
    logic        chk;
    logic        sts;
    logic [1:0]  ide;
    logic [3:0]  st_len;
    logic [3:0]  sp_len;
  } sirq_exp_s;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cfg_addr = 8'h00;
  logic        cfg_wr = 1'b0;
  sirq_byte_t  cfg_wdata = 8'h00;
  sirq_byte_t  cfg_rdata_q;
  logic        line_out, oe_n, smi_n, chk, sts, drv_low, done_q;
  logic        kick = 1'b0, p_rst = 1'b1, smi_status_clr = 1'b0;
  logic        exp_sts = 1'b0;
  logic [3:0]  pci_int_n = 4'hF, pci_q, st_len, sp_len, run = 4'h0;
  logic [1:0]  ide_irq_in = 2'h0, bmide, phase_q;
  logic [15:0] isa;
  logic [20:0] frame_lvl = 21'h1F_FFFF;
  wire  logic  line = !((!oe_n && !line_out) || drv_low);
  sirq_exp_s   exp_q[$];
  sirq_exp_s   e;
  sirq_exp_s   got;
  int          num_errors = 0;
  int          n_checks = 0;
  sirq_host sirq_host_i (.sys_clk(sys_clk), .rst(rst), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .serial_irq_line_in(line), .serial_irq_line_out_q(line_out),
    .serial_irq_line_oe_n_q(oe_n), .pci_int_n(pci_int_n),
    .ide_irq_in(ide_irq_in), .smi_status_clr(smi_status_clr),
    .isa_irq_q(isa), .pci_irq_route_q(pci_q),
    .system_mgmt_interrupt_n_q(smi_n), .serial_smi_status_q(sts),
    .io_channel_check_frame_q(chk), .bmide_irq_q(bmide));
  sirq_periph sirq_periph_i (.sys_clk(sys_clk), .p_rst(p_rst), .line(line),
    .frame_lvl(frame_lvl), .kick(kick), .drv_low(drv_low),
    .phase_q(phase_q), .done_q(done_q));
  always #25 sys_clk = ~sys_clk;
  task complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk_val(input logic [31:0] e_v, input logic [31:0] g_v);
    n_checks++;
    if (g_v !== e_v) begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e_v, g_v);
    end
  endtask
  task chk_cyc(input sirq_exp_s e_v, input sirq_exp_s g_v);
    n_checks++;
    if (g_v !== e_v) begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e_v, g_v);
    end
  endtask
  task wr(input logic [7:0] a, input sirq_byte_t d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    cfg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input sirq_byte_t x);
    cfg_addr = a;
    @(posedge sys_clk);
    #1;
    chk_val({24'h0, x}, {24'h0, cfg_rdata_q});
  endtask
  task wait_done;
    int t;
    t = 0;
    while (done_q !== 1'b1 && t < 300) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    if (t >= 300) chk_val(32'h1, 32'h0);
  endtask
  // Lengths of the host's own low runs, split into start and stop frames.
  always @(posedge sys_clk) begin
    if (!oe_n && !line_out) run <= run + 4'd1;
    else if (run != 4'd0) begin
      run <= 4'd0;
      if (phase_q == 2'd1) st_len <= run;
      else sp_len <= run;
    end
  end
  initial forever begin
    @(posedge sys_clk);
    #1;
    if (done_q === 1'b1) begin
      repeat (3) @(posedge sys_clk);
      #1;
      got = {isa, pci_q, smi_n, chk, sts, bmide, st_len, sp_len};
      if (exp_q.size() == 0) chk_val(32'h1, 32'h0);
      else chk_cyc(exp_q.pop_front(), got);
    end
  end
  // About 2200 cycles are needed, so this only trips on a hang.
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    complete_run;
  end
  initial begin
    logic [3:0] w;
    void'($urandom(32'h0b2e_e2fd));
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk_val({16'h0, 4'hF, 5'b10011, 2'h0, 5'h0},
            {isa, pci_q, smi_n, chk, sts, oe_n, line_out, bmide, 5'h0});
    rd(8'h64, 8'h00);
    wr(8'h64, 8'hFF);
    rd(8'h64, 8'hC3);
    wr(8'h65, 8'h00);
    rd(8'h65, 8'h00);
    rd(8'h64, 8'hC3);
    for (int m = 0; m < 8; m++) begin
      wr(8'h64, 8'h00);
      smi_status_clr = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      p_rst = 1'b1;
      smi_status_clr = 1'b0;
      @(posedge sys_clk);
      #1;
      p_rst = 1'b0;
      exp_sts = 1'b0;
      w = (m[1:0] == 2'd0) ? 4'd4 : (m[1:0] == 2'd1) ? 4'd6 : 4'd8;
      wr(8'h64, {1'b1, m[2], 4'h0, m[1:0]});
      for (int c = 0; c < 3; c++) begin
        frame_lvl = 21'($urandom);
        pci_int_n = 4'($urandom);
        ide_irq_in = 2'($urandom);
        exp_sts = exp_sts | !frame_lvl[2];
        e.isa = frame_lvl[15:0] & ~16'h2105;
        e.pci = frame_lvl[20:17] & pci_int_n;
        e.smi_n = frame_lvl[2];
        e.chk = !frame_lvl[16];
        e.sts = exp_sts;
        e.ide = ide_irq_in;
        e.st_len = (!m[2] && c > 0) ? w - 4'd1 : w;
        e.sp_len = m[2] ? 4'd3 : 4'd2;
        exp_q.push_back(e);
        if (!m[2] && c > 0) begin
          repeat (20) @(posedge sys_clk);
          #1;
          chk_val(32'h1, {31'h0, oe_n});
          kick = 1'b1;
          @(posedge sys_clk);
          #1;
          kick = 1'b0;
        end
        wait_done;
        repeat (4) @(posedge sys_clk);
        #1;
      end
      $display("test mode %0d done", m);
    end
    wr(8'h64, 8'h00);
    complete_run;
  end
endmodule // tb
